// file: sim/tb_top.sv
// Self-checking bench: software side over AHB-Lite, flash partner on the pins.
// Assumes the controller answers with hreadyout always high, one data phase per transfer.
`timescale 1ns/100ps
`default_nettype none
`include "wbp_map.svh"
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [7:0]  haddr = 8'h00;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [15:0] hdq;
  logic [15:0] fdq;
  logic        dq_oe;
  logic [23:0] faddr;
  logic        ce_n;
  logic        we_n;
  logic        oe_n;
  logic        frst_n;
  logic        rdy;
  logic [15:0] words [$];
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;
  // Undriven data lines show the inverse, so a missing drive is caught
  wire  [15:0] fdata = dq_oe ? hdq : ~hdq;

  wbp_ctrl #(.SETUP_CYC(2), .PULSE_CYC(4), .HOLD_CYC(2)) uut (
    .sys_clk_in(clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .flash_dq_in(fdq),
    .flash_dq_out(hdq), .flash_dq_oe_out(dq_oe), .flash_addr_out(faddr),
    .flash_ce_n_out(ce_n), .flash_we_n_out(we_n), .flash_oe_n_out(oe_n),
    .flash_reset_n_out(frst_n), .ready_busy_in(rdy));
  wbp_flash_model #(.PROT_SECT(8'h3f)) flash (
    .clk_in(clk), .reset_n_in(frst_n), .ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n),
    .addr_in(faddr), .wdata_in(fdata), .dq_out(fdq), .ready_busy_out(rdy));

  always #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus transfers and comparisons
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t word got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk32(r & m, e & m);
    chk32({31'h0, hresp}, 32'h0);
  endtask
  // Expected status word; ready bit high whenever the flash idles
  function automatic logic [31:0] exp_st(input logic dn, fl, ab, rf);
    exp_st = 32'h0;
    exp_st[`WBP_ST_RDY] = 1'b1;
    exp_st[`WBP_ST_DONE] = dn;
    exp_st[`WBP_ST_FAIL] = fl;
    exp_st[`WBP_ST_ABORTED] = ab;
    exp_st[`WBP_ST_REFUSED] = rf;
  endfunction
  function automatic logic [15:0] mem_rd(input logic [23:0] a);
    return flash.mem.exists(int'(a)) ? flash.mem[int'(a)] : 16'hffff;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Fill the buffer at the line offset, then launch; optional stop mid-load
  task automatic run_go(input logic [23:0] s, input logic [7:0] n, input logic ab, clr);
    if (clr) wr(`WBP_REG_CTRL, 32'h4);
    wr(`WBP_REG_START, {8'h00, s});
    wr(`WBP_REG_COUNT, {24'h0, n});
    wr(`WBP_REG_PTR, {24'h0, s[7:0]});
    words.delete();
    for (int i = 0; i <= n; i++) begin
      words.push_back(16'($urandom));
      wr(`WBP_REG_DATA, {16'h0, words[i]});
    end
    wr(`WBP_REG_CTRL, 32'h1);
    if (ab) begin
      repeat (150) @(posedge clk);
      wr(`WBP_REG_CTRL, 32'h2);
    end
  endtask
  task automatic run_end;
    logic [31:0] r;
    r = 32'h1;
    for (int i = 0; i < 3000 && r[0] !== 1'b0; i++) xfer(1'b0, `WBP_REG_STATUS, 32'h0, r);
  endtask
  task automatic mem_chk(input logic [23:0] s, input logic ok);
    foreach (words[i]) chk16(mem_rd(s + 24'(i)), ok ? words[i] : 16'hffff);
  endtask

  task automatic give_verdict;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Hang guard well above the longest expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: random lines, boundaries, refusal, abort, protection, clear
  initial begin
    logic [23:0] s;
    logic [7:0]  n;
    void'($urandom(79));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`WBP_REG_STATUS, 32'hffffffff, exp_st(0, 0, 0, 0));
    wr(8'h18, 32'hffffffff);
    rd_chk(8'h18, 32'hffffffff, 32'h0);
    for (int k = 0; k < 4; k++) begin
      s = {8'h01 + 8'(k), 16'($urandom)};
      n = 8'($urandom % (256 - s[7:0]));
      if (k == 3) s[7:0] = 8'h80;
      if (k == 3) n = 8'h7f;
      run_go(s, n, 1'b0, 1'b1);
      run_end();
      rd_chk(`WBP_REG_STATUS, 32'h1f, exp_st(1, 0, 0, 0));
      mem_chk(s, 1'b1);
    end
    flash.busy_len = 400;
    run_go(24'h050000, 8'hff, 1'b0, 1'b1);
    for (int i = 0; i < 4000 && rdy !== 1'b0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    rd_chk(`WBP_REG_STATUS, 32'h21, 32'h01);
    run_end();
    rd_chk(`WBP_REG_STATUS, 32'h1f, exp_st(1, 0, 0, 0));
    mem_chk(24'h050000, 1'b1);
    flash.busy_len = 40;
    run_go(24'h060080, 8'h80, 1'b0, 1'b1);
    run_end();
    rd_chk(`WBP_REG_STATUS, 32'h1f, exp_st(0, 0, 0, 1));
    mem_chk(24'h060080, 1'b0);
    run_go(24'h070010, 8'hc8, 1'b1, 1'b1);
    run_end();
    rd_chk(`WBP_REG_STATUS, 32'h1e, exp_st(0, 1, 1, 0));
    mem_chk(24'h070010, 1'b0);
    run_go(24'h080040, 8'h05, 1'b0, 1'b0);
    run_end();
    rd_chk(`WBP_REG_STATUS, 32'h06, exp_st(1, 0, 0, 0));
    mem_chk(24'h080040, 1'b1);
    run_go(24'h3f0100, 8'h03, 1'b0, 1'b1);
    run_end();
    rd_chk(`WBP_REG_STATUS, 32'h1e, exp_st(0, 1, 0, 0));
    mem_chk(24'h3f0100, 1'b0);
    wr(`WBP_REG_CTRL, 32'h4);
    rd_chk(`WBP_REG_STATUS, 32'h1e, 32'h0);
    run_go(24'h090000, 8'h01, 1'b0, 1'b1);
    run_end();
    rd_chk(`WBP_REG_STATUS, 32'h1f, exp_st(1, 0, 0, 0));
    mem_chk(24'h090000, 1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire

// file: sim/wbp_flash_model.sv
// Behavioural flash partner: command sequencer for buffered line programming.
// Assumes pins change on the host clock; released data lines toggle every cycle.
`timescale 1ns/100ps
`default_nettype none
module wbp_flash_model #(
  parameter logic [7:0] PROT_SECT = 8'h3f
) (
  // Clock and host pins
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        ce_n_in,
  input  wire logic        we_n_in,
  input  wire logic        oe_n_in,
  input  wire logic [23:0] addr_in,
  input  wire logic [15:0] wdata_in,
  // Answers to the host
  output logic [15:0]      dq_out,
  output logic             ready_busy_out
);
  logic [15:0] mem  [int];
  logic [15:0] wbuf [int];
  logic [23:0] sa;
  logic [23:0] nxt;
  logic [15:0] ln;
  logic [15:0] last;
  logic [15:0] v;
  logic [7:0]  cnt;
  logic [3:0]  st = 4'h0;
  logic        first = 1'b0;
  logic        we_d = 1'b1;
  int          busy_len = 40;
  int          busy_cnt = 0;
  initial dq_out = 16'h0000;
  initial ready_busy_out = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // One completed write cycle steps the command sequence
  task automatic take(input logic [23:0] a, input logic [15:0] d);
    case (st)
      4'h0: st = (a == 24'h000555 && d == 16'h00aa) ? 4'h1 : 4'h0;
      4'h1: st = (a == 24'h0002aa && d == 16'h0055) ? 4'h2 : 4'h0;
      4'h2: begin
        sa = a;
        st = (d == 16'h0025) ? 4'h3 : 4'h0;
      end
      4'h3: begin
        cnt = d[7:0];
        first = 1'b1;
        wbuf.delete();
        st = (a[23:16] != sa[23:16] || d > 16'h00ff) ? 4'h7 : 4'h4;
      end
      4'h4: begin
        if (first ? a[23:16] != sa[23:16] : (a != nxt || a[23:8] != ln)) st = 4'h7;
        else begin
          first = 1'b0;
          ln = a[23:8];
          nxt = a + 24'h1;
          wbuf[a] = d;
          last = d;
          if (cnt == 8'h00) st = 4'h5;
          else cnt = cnt - 8'h1;
        end
      end
      4'h5: begin
        busy_cnt = 0;
        st = (d == 16'h0029 && a[23:16] == sa[23:16]) ? 4'h6 : 4'h7;
      end
      // busy ignores writes; reset leaves fail
      default: if (d == 16'h00f0 && st > 4'h6) st = 4'h0;
    endcase
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Data is taken on the rising write strobe, as the real part does
  always @(posedge clk_in) begin
    if (!reset_n_in) st = 4'h0;
    else if (!we_d && we_n_in && !ce_n_in) take(addr_in, wdata_in);
    we_d = we_n_in;
    if (st == 4'h6) begin
      busy_cnt++;
      if (busy_cnt >= busy_len) begin
        if (sa[23:16] == PROT_SECT) st = 4'h8;
        else begin
          foreach (wbuf[k]) mem[k] = wbuf[k];
          st = 4'h0;
        end
      end
    end
    // poll bits while busy or failed
    v = 16'h0000;
    v[7] = ~last[7];
    v[1] = (st == 4'h7);
    v[5] = (st == 4'h8);
    if (st < 4'h6) v = mem.exists(int'(addr_in)) ? mem[int'(addr_in)] : 16'hffff;
    dq_out <= (!ce_n_in && !oe_n_in) ? v : ~dq_out;
    ready_busy_out <= (st != 4'h6);
  end
endmodule
`default_nettype wire

// file: verilog/wbp_bus_cycle.sv
// Pin cycle engine: runs one asynchronous write or read cycle on the flash pins.
// Assumes requests arrive only while busy_out is low; dq_in is asynchronous to sys_clk_in.
`timescale 1ns/100ps
`default_nettype none
module wbp_bus_cycle
  import wbp_pkg::*;
#(
  parameter int SETUP_CYC = 2,
  parameter int PULSE_CYC = 4,
  parameter int HOLD_CYC  = 2
) (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // Request side
  input  wire logic        req_valid_in,
  input  wire wbp_cyc_s    req_in,
  output logic             busy_out,
  output logic             done_out,
  output logic [15:0]      rdata_out,
  // Flash pins
  input  wire logic [15:0] dq_in,
  output logic [15:0]      dq_out,
  output logic             dq_oe_out,
  output logic [23:0]      addr_out,
  output logic             ce_n_out,
  output logic             we_n_out,
  output logic             oe_n_out
);
  wbp_phase_e  phase, next_phase;
  logic [3:0]  cnt, next_cnt;
  logic        rd, next_rd, next_done;
  logic [15:0] dq_s1, dq_s2, next_rdata, next_dq;
  logic [23:0] next_addr;

  assign busy_out = (phase != WBP_PH_IDLE);

  //////////////////////////////////////////////////////////////////////////////
  // Phase sequencing; read data taken at the end of the pulse
  always_comb begin
    next_phase = phase;
    next_cnt   = cnt;
    next_rd    = rd;
    next_done  = 1'b0;
    next_rdata = rdata_out;
    next_addr  = addr_out;
    next_dq    = dq_out;
    unique case (phase)
      WBP_PH_IDLE: begin
        if (req_valid_in) begin
          next_phase = WBP_PH_SETUP;
          next_cnt   = 4'(SETUP_CYC - 1);
          next_rd    = req_in.rd;
          next_addr  = req_in.addr;
          next_dq    = req_in.data;
        end
      end
      WBP_PH_SETUP: begin
        if (cnt == 4'h0) begin
          next_phase = WBP_PH_PULSE;
          next_cnt   = 4'(PULSE_CYC - 1);
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      WBP_PH_PULSE: begin
        if (cnt == 4'h0) begin
          next_phase = WBP_PH_HOLD;
          next_cnt   = 4'(HOLD_CYC - 1);
          next_rdata = dq_s2;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      WBP_PH_HOLD: begin
        if (cnt == 4'h0) begin
          next_phase = WBP_PH_IDLE;
          next_done  = 1'b1;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
    endcase
  end

  // Registers; pins come straight from flops to avoid glitches on strobes
  always_ff @(posedge sys_clk_in) begin
    dq_s1 <= dq_in;
    dq_s2 <= dq_s1;
    if (rst_in) begin
      phase     <= WBP_PH_IDLE;
      cnt       <= 4'h0;
      rd        <= 1'b0;
      done_out  <= 1'b0;
      rdata_out <= 16'h0000;
      addr_out  <= 24'h000000;
      dq_out    <= 16'h0000;
      dq_oe_out <= 1'b0;
      ce_n_out  <= 1'b1;
      we_n_out  <= 1'b1;
      oe_n_out  <= 1'b1;
    end else begin
      phase     <= next_phase;
      cnt       <= next_cnt;
      rd        <= next_rd;
      done_out  <= next_done;
      rdata_out <= next_rdata;
      addr_out  <= next_addr;
      dq_out    <= next_dq;
      dq_oe_out <= (next_phase != WBP_PH_IDLE) && !next_rd;
      ce_n_out  <= (next_phase == WBP_PH_IDLE);
      we_n_out  <= !((next_phase == WBP_PH_PULSE) && !next_rd);
      oe_n_out  <= !((next_phase == WBP_PH_PULSE) && next_rd);
    end
  end
endmodule
`default_nettype wire

// file: verilog/wbp_ctrl.sv
// Buffered program controller: AHB-Lite registers, line buffer and command sequencer.
// Assumes one flash on the pins and software that fills the buffer before GO.
`timescale 1ns/100ps
`default_nettype none
`include "wbp_map.svh"
module wbp_ctrl
  import wbp_pkg::*;
#(
  parameter int SETUP_CYC = 2,
  parameter int PULSE_CYC = 4,
  parameter int HOLD_CYC  = 2
) (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [7:0]  haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Flash pins
  input  wire logic [15:0] flash_dq_in,
  output logic [15:0]      flash_dq_out,
  output logic             flash_dq_oe_out,
  output logic [23:0]      flash_addr_out,
  output logic             flash_ce_n_out,
  output logic             flash_we_n_out,
  output logic             flash_oe_n_out,
  output logic             flash_reset_n_out,
  input  wire logic        ready_busy_in
);
  logic [15:0] buffer_line_location [256];
  wbp_state_e  state, next_state;
  logic        issued, next_issued, req_v, cyc_busy, cyc_done, rb_s1, rb_s2;
  wbp_cyc_s    req;
  logic [15:0] rdata;
  logic [7:0]  idx, next_idx, ptr, next_ptr, word_count_minus_one, next_wc;
  logic [23:0] start, next_start;
  logic [3:0]  sticky, next_sticky, set_st;
  logic        dph_wr, go_req, abort_req, next_abort_req;
  logic [7:0]  dph_addr;
  logic [31:0] next_hrdata;
  logic        data_wr;
  logic        poll_match;

  // Line address of the n-th loaded word
  function automatic logic [23:0] line_addr(input logic [23:0] s, input logic [7:0] n);
    line_addr = {s[23:`WBP_LINE_BITS], s[7:0] + n};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin cycle engine
  wbp_bus_cycle #(
    .SETUP_CYC (SETUP_CYC),
    .PULSE_CYC (PULSE_CYC),
    .HOLD_CYC  (HOLD_CYC)
  ) u_cycle (
    .sys_clk_in   (sys_clk_in),
    .rst_in       (rst_in),
    .req_valid_in (req_v),
    .req_in       (req),
    .busy_out     (cyc_busy),
    .done_out     (cyc_done),
    .rdata_out    (rdata),
    .dq_in        (flash_dq_in),
    .dq_out       (flash_dq_out),
    .dq_oe_out    (flash_dq_oe_out),
    .addr_out     (flash_addr_out),
    .ce_n_out     (flash_ce_n_out),
    .we_n_out     (flash_we_n_out),
    .oe_n_out     (flash_oe_n_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, read data registered at the address phase
  always_comb begin
    next_hrdata = 32'h00000000;
    unique case (haddr_in)
      `WBP_REG_START:  next_hrdata = {8'h00, start};
      `WBP_REG_COUNT:  next_hrdata = {24'h000000, word_count_minus_one};
      `WBP_REG_PTR:    next_hrdata = {24'h000000, ptr};
      `WBP_REG_STATUS: next_hrdata = {26'h0, rb_s2, sticky, state != WBP_IDLE};
      default:         next_hrdata = 32'h00000000;
    endcase
  end

  // Write decode in the data phase; start and count lock while a sequence runs
  assign data_wr = dph_wr && (dph_addr == `WBP_REG_DATA);
  assign go_req  = dph_wr && (dph_addr == `WBP_REG_CTRL) && hwdata_in[`WBP_CTRL_GO];
  always_comb begin
    next_start     = start;
    next_wc        = word_count_minus_one;
    next_ptr       = data_wr ? ptr + 8'h01 : ptr;
    next_abort_req = abort_req && (state != WBP_IDLE);
    if (dph_wr && state == WBP_IDLE) begin
      if (dph_addr == `WBP_REG_START) next_start = hwdata_in[23:0];
      if (dph_addr == `WBP_REG_COUNT) next_wc = hwdata_in[7:0];
    end
    if (dph_wr && dph_addr == `WBP_REG_PTR) next_ptr = hwdata_in[7:0];
    if (dph_wr && dph_addr == `WBP_REG_CTRL && hwdata_in[`WBP_CTRL_ABORT]) next_abort_req = 1'b1;
    // Set wins over clear
    next_sticky = sticky | set_st;
    if (dph_wr && dph_addr == `WBP_REG_CTRL && hwdata_in[`WBP_CTRL_CLEAR])
      next_sticky = set_st;
    if (set_st[`WBP_ST_DONE - 1]) next_sticky[`WBP_ST_FAIL - 1] = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer: each step issues one flash cycle and advances when it completes
  assign poll_match = rdata[`WBP_POLL_DATA_BIT] ==
    buffer_line_location[8'(start[7:0] + word_count_minus_one)][`WBP_POLL_DATA_BIT];
  always_comb begin
    next_state  = state;
    next_idx    = idx;
    next_issued = issued && !cyc_done;
    set_st      = 4'h0;
    req         = '{rd: 1'b0, addr: start, data: 16'h0000};
    unique case (state)
      WBP_IDLE: begin
        if (go_req) begin
          // refuse a range past the line end
          if ({1'b0, start[7:0]} + {1'b0, word_count_minus_one} > `WBP_LINE_LAST)
            set_st[`WBP_ST_REFUSED - 1] = 1'b1;
          else
            next_state = WBP_UNLK1;
          next_idx = 8'h00;
        end
      end
      WBP_UNLK1: req = '{rd: 1'b0, addr: `WBP_UNLK1_ADDR, data: `WBP_UNLK1_DATA};
      WBP_UNLK2: req = '{rd: 1'b0, addr: `WBP_UNLK2_ADDR, data: `WBP_UNLK2_DATA};
      // load command to the start address, same sector
      WBP_CMD:   req.data = `WBP_CMD_LOAD;
      // count minus one to the same sector
      WBP_COUNT: req.data = {8'h00, word_count_minus_one};
      WBP_LOAD: begin
        req.addr = line_addr(start, idx);
        req.data = buffer_line_location[8'(start[7:0] + idx)];
      end
      // confirm right after the last word
      WBP_CONFIRM: req.data = `WBP_CMD_CONFIRM;
      // data polling at the last loaded word
      WBP_POLL, WBP_RECHK: req = '{rd: 1'b1, addr: line_addr(start, word_count_minus_one),
                                    data: 16'h0000};
      // stop the load by writing outside the line
      WBP_ABORT: req.addr = start ^ 24'(1 << `WBP_LINE_BITS);
      // reset command back to read mode
      WBP_RESET: req.data = `WBP_CMD_RESET;
      default: ;
    endcase
    req_v = (state != WBP_IDLE) && !issued && !cyc_busy;
    if (req_v) next_issued = 1'b1;
    if (cyc_done) begin
      unique case (state)
        WBP_UNLK1:   next_state = WBP_UNLK2;
        WBP_UNLK2:   next_state = WBP_CMD;
        WBP_CMD:     next_state = WBP_COUNT;
        WBP_COUNT:   next_state = abort_req ? WBP_ABORT : WBP_LOAD;
        WBP_LOAD: begin
          next_idx = idx + 8'h01;
          if (abort_req) next_state = WBP_ABORT;
          else if (idx == word_count_minus_one) next_state = WBP_CONFIRM;
        end
        WBP_CONFIRM: next_state = WBP_POLL;
        WBP_POLL: begin
          if (poll_match) begin
            next_state = WBP_IDLE;
            set_st[`WBP_ST_DONE - 1] = 1'b1;
          end else if (rdata[`WBP_POLL_FAIL_BIT] || rdata[`WBP_POLL_ABORT_BIT]) begin
            next_state = WBP_RECHK;
          end
        end
        WBP_RECHK: begin
          // recheck data bit before declaring failure
          if (poll_match) begin
            next_state = WBP_IDLE;
            set_st[`WBP_ST_DONE - 1] = 1'b1;
          end else begin
            next_state = WBP_RESET;
            set_st[`WBP_ST_FAIL - 1]    = 1'b1;
            set_st[`WBP_ST_ABORTED - 1] = rdata[`WBP_POLL_ABORT_BIT];
          end
        end
        WBP_ABORT: begin
          next_state = WBP_RESET;
          set_st[`WBP_ST_ABORTED - 1] = 1'b1;
          set_st[`WBP_ST_FAIL - 1]    = 1'b1;
        end
        WBP_RESET:   next_state = WBP_IDLE;
        default:     next_state = WBP_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers; the buffer array is written directly, no reset on purpose
  always_ff @(posedge sys_clk_in) begin
    if (data_wr) buffer_line_location[ptr] <= hwdata_in[15:0];
    rb_s1 <= ready_busy_in;
    rb_s2 <= rb_s1;
    if (rst_in) begin
      state                <= WBP_IDLE;
      issued               <= 1'b0;
      idx                  <= 8'h00;
      ptr                  <= 8'h00;
      start                <= 24'h000000;
      word_count_minus_one <= 8'h00;
      sticky               <= 4'h0;
      abort_req            <= 1'b0;
      dph_wr               <= 1'b0;
      dph_addr             <= 8'h00;
      hrdata_out           <= 32'h00000000;
      hreadyout_out        <= 1'b1;
      hresp_out            <= 1'b0;
      flash_reset_n_out    <= 1'b1;
    end else begin
      state                <= next_state;
      issued               <= next_issued;
      idx                  <= next_idx;
      ptr                  <= next_ptr;
      start                <= next_start;
      word_count_minus_one <= next_wc;
      sticky               <= next_sticky;
      abort_req            <= next_abort_req;
      dph_wr               <= hsel_in && htrans_in[1] && hready_in && hwrite_in;
      dph_addr             <= haddr_in;
      hrdata_out           <= next_hrdata;
      hreadyout_out        <= 1'b1;
      hresp_out            <= 1'b0;
      flash_reset_n_out    <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  unlk1_pins_a: assert property (state == WBP_UNLK1 && !flash_we_n_out |->
    flash_addr_out == `WBP_UNLK1_ADDR && flash_dq_out == `WBP_UNLK1_DATA)
    else $error("first unlock write wrong");
  unlk2_pins_a: assert property (state == WBP_UNLK2 && !flash_we_n_out |->
    flash_addr_out == `WBP_UNLK2_ADDR && flash_dq_out == `WBP_UNLK2_DATA)
    else $error("second unlock write wrong");
  load_cmd_a: assert property (state == WBP_CMD && !flash_we_n_out |->
    flash_dq_out == `WBP_CMD_LOAD && flash_addr_out == start) else $error("load command wrong");
  count_word_a: assert property (state == WBP_COUNT && !flash_we_n_out |->
    flash_dq_out == {8'h00, word_count_minus_one}) else $error("count write wrong");
  load_in_line_a: assert property (state == WBP_LOAD && !flash_we_n_out |->
    flash_addr_out == line_addr(start, idx)) else $error("load address out of order");
  confirm_next_a: assert property (state == WBP_LOAD && cyc_done && !abort_req &&
    idx == word_count_minus_one |=> state == WBP_CONFIRM) else $error("confirm not next");
  stop_outside_a: assert property (state == WBP_ABORT && !flash_we_n_out |->
    flash_addr_out[23:8] != start[23:8]) else $error("stop write inside line");
  fail_reset_a: assert property (state == WBP_RECHK && cyc_done && !poll_match |=>
    state == WBP_RESET) else $error("no reset after failure");
  abort_flags_a: assert property (state == WBP_ABORT && cyc_done |=>
    sticky[`WBP_ST_FAIL - 1] && sticky[`WBP_ST_ABORTED - 1]) else $error("abort flags not set");
  strobe_excl_a: assert property (!(!flash_we_n_out && !flash_oe_n_out))
    else $error("write and read strobes together");
  done_cov: cover property (state == WBP_POLL && cyc_done && poll_match);
  abort_cov: cover property (state == WBP_ABORT && cyc_done);
  refuse_cov: cover property (set_st[`WBP_ST_REFUSED - 1]);
endmodule
`default_nettype wire

// file: verilog/wbp_map.svh
// Address map, command words and field positions of the buffered program controller.
// Assumes word addressing on the flash side and 32-bit AHB-Lite data on the software side.
`ifndef WBP_MAP_SVH
`define WBP_MAP_SVH
// Software register offsets, one aligned word each
`define WBP_REG_CTRL    8'h00
`define WBP_REG_START   8'h04
`define WBP_REG_COUNT   8'h08
`define WBP_REG_PTR     8'h0c
`define WBP_REG_DATA    8'h10
`define WBP_REG_STATUS  8'h14
// Control bits (write one, self clearing)
`define WBP_CTRL_GO     0
`define WBP_CTRL_ABORT  1
`define WBP_CTRL_CLEAR  2
// Status bits
`define WBP_ST_ACTIVE   0
`define WBP_ST_DONE     1
`define WBP_ST_FAIL     2
`define WBP_ST_ABORTED  3
`define WBP_ST_REFUSED  4
`define WBP_ST_RDY      5
// Flash command sequence
`define WBP_UNLK1_ADDR  24'h000555
`define WBP_UNLK1_DATA  16'h00aa
`define WBP_UNLK2_ADDR  24'h0002aa
`define WBP_UNLK2_DATA  16'h0055
`define WBP_CMD_LOAD    16'h0025
`define WBP_CMD_CONFIRM 16'h0029
`define WBP_CMD_RESET   16'h00f0
// Line geometry: 256 words, 512 bytes
`define WBP_LINE_BITS   8
`define WBP_LINE_LAST   9'h0ff
// Poll bits on the data bus
`define WBP_POLL_DATA_BIT  7
`define WBP_POLL_FAIL_BIT  5
`define WBP_POLL_ABORT_BIT 1
`endif

// file: verilog/wbp_pkg.sv
// Types shared by the buffered program controller and its pin cycle engine.
// Assumes the map header supplies all numeric constants.
package wbp_pkg;
  // Controller states
  typedef enum logic [3:0] {
    WBP_IDLE    = 4'h0,
    WBP_UNLK1   = 4'h1,
    WBP_UNLK2   = 4'h2,
    WBP_CMD     = 4'h3,
    WBP_COUNT   = 4'h4,
    WBP_LOAD    = 4'h5,
    WBP_CONFIRM = 4'h6,
    WBP_POLL    = 4'h7,
    WBP_RECHK   = 4'h8,
    WBP_ABORT   = 4'h9,
    WBP_RESET   = 4'ha
  } wbp_state_e;
  // Engine phases
  typedef enum logic [1:0] {
    WBP_PH_IDLE  = 2'h0,
    WBP_PH_SETUP = 2'h1,
    WBP_PH_PULSE = 2'h2,
    WBP_PH_HOLD  = 2'h3
  } wbp_phase_e;
  // One flash bus cycle request
  typedef struct packed {
    logic        rd;
    logic [23:0] addr;
    logic [15:0] data;
  } wbp_cyc_s;
endpackage
